// ---- ifer_core.sv ----
// Interrupt request flags, enable bits and register port of the block
//
// How it works
// - Pin interrupt passes only while enable-one bit 0 is set.
// - Low timer match interrupt passes only while enable-two bit 2 set.
// - Reload timer interrupt passes only while enable-two bit 1 set.
// - Pin flag sets on selected edge when pin is an interrupt input.
// - Writing zero to the set pin flag clears it.
// - Low timer flag sets on counter equal compare in 8-bit mode.
// - Writing zero to the set low timer flag clears it.
// - Reload flag sets when its counter wraps FF to 00 or 00 to FF.
// - Writing zero to the set reload flag clears it.
// - Low half counter is a readable, writable 8-bit up-counter.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module ifer_core
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ifer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ifer_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [ifer_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ext_interrupt_pin,
  input wire logic [7:0] reload_count,
  output logic ext_pin_int,
  output logic low_timer_match_int,
  output logic reload_timer_int,
  output logic cpu_irq
);
  import ifer_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic ext_pin_int_enable;
    logic low_timer_match_int_enable;
    logic reload_timer_int_enable;
    logic ext_pin_request_flag;
    logic low_timer_match_request_flag;
    logic reload_timer_request_flag;
    logic [7:0] control;
    logic [7:0] compare;
    logic [7:0] rdata;
    logic [7:0] reload_prev;
    logic reload_prev_ok;
    logic ext_int;
    logic low_int;
    logic reload_int;
    logic irq;
  } ifer_core_t;

  ifer_core_t st;
  ifer_core_t next_st;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  ifer_evt_if evt ();

  logic wr_enable_one;
  logic wr_enable_two;
  logic wr_request_one;
  logic wr_request_two;
  logic wr_counter;
  logic wr_compare;
  logic wr_control;
  logic reload_wrap;
  logic low_match_event;
  logic [7:0] enable_one_view;
  logic [7:0] enable_two_view;
  logic [7:0] request_one_view;
  logic [7:0] request_two_view;

  // Strobe decode shared by every write target
  function automatic logic hit
  (
    input logic strobe,
    input logic [15:0] addr,
    input logic [15:0] target
  );
    hit = strobe && (addr == target);
  endfunction : hit

  // Clear only on a written zero; a written one leaves the flag alone
  function automatic logic next_flag
  (
    input logic flag,
    input logic set,
    input logic wr,
    input logic wbit
  );
    next_flag = (flag & ~(wr & ~wbit)) | set;
  endfunction : next_flag

  ifer_pin_edge u_pin_edge
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ext_interrupt_pin(ext_interrupt_pin),
    .evt(evt.pin)
  );

  ifer_low_timer u_low_timer
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .evt(evt.timer)
  );

  // ------------------------------------------------------------------
  // Write decode and helper controls
  // ------------------------------------------------------------------
  always_comb
  begin
    wr_enable_one = hit(reg_write, reg_addr, ADDR_INT_ENABLE_ONE);
    wr_enable_two = hit(reg_write, reg_addr, ADDR_INT_ENABLE_TWO);
    wr_request_one = hit(reg_write, reg_addr, ADDR_INT_REQUEST_ONE);
    wr_request_two = hit(reg_write, reg_addr, ADDR_INT_REQUEST_TWO);
    wr_counter = hit(reg_write, reg_addr, ADDR_LOW_HALF_COUNTER);
    wr_compare = hit(reg_write, reg_addr, ADDR_LOW_HALF_COMPARE);
    wr_control = hit(reg_write, reg_addr, ADDR_EVENT_CONTROL);
  end

  assign evt.pin_irq_mode = st.control[CTRL_PIN_IRQ_MODE_BIT];
  assign evt.pin_rising = st.control[CTRL_PIN_RISING_BIT];
  assign evt.mode_8bit = st.control[CTRL_MODE_8BIT_BIT];
  assign evt.clear_on_match = st.control[CTRL_CLEAR_ON_MATCH_BIT];
  assign evt.count_load = wr_counter;
  assign evt.count_wdata = reg_wdata;
  assign evt.compare = st.compare;

  // ------------------------------------------------------------------
  // Event detection
  // ------------------------------------------------------------------
  always_comb
  begin
    // A wrap is judged only against a sample taken after reset
    reload_wrap = st.reload_prev_ok &&
                  ((st.reload_prev == WRAP_HIGH &&
                    reload_count == WRAP_LOW) ||
                   (st.reload_prev == WRAP_LOW &&
                    reload_count == WRAP_HIGH));
    // Timer only matches in 8-bit mode; gated again for a mode change
    low_match_event = evt.match & evt.mode_8bit;
  end

  // ------------------------------------------------------------------
  // Register views
  // ------------------------------------------------------------------
  always_comb
  begin
    enable_one_view = '0;
    enable_two_view = '0;
    request_one_view = '0;
    request_two_view = '0;
    enable_one_view[EXT_PIN_BIT] = st.ext_pin_int_enable;
    enable_two_view[LOW_TIMER_MATCH_BIT] = st.low_timer_match_int_enable;
    enable_two_view[RELOAD_TIMER_BIT] = st.reload_timer_int_enable;
    request_one_view[EXT_PIN_BIT] = st.ext_pin_request_flag;
    request_two_view[LOW_TIMER_MATCH_BIT] =
      st.low_timer_match_request_flag;
    request_two_view[RELOAD_TIMER_BIT] = st.reload_timer_request_flag;
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.reload_prev = reload_count;
    next_st.reload_prev_ok = 1'b1;

    if (wr_enable_one)
    begin
      next_st.ext_pin_int_enable = reg_wdata[EXT_PIN_BIT];
    end
    if (wr_enable_two)
    begin
      next_st.low_timer_match_int_enable =
        reg_wdata[LOW_TIMER_MATCH_BIT];
      next_st.reload_timer_int_enable = reg_wdata[RELOAD_TIMER_BIT];
    end
    if (wr_compare)
    begin
      next_st.compare = reg_wdata;
    end
    if (wr_control)
    begin
      next_st.control = reg_wdata & CTRL_MASK;
    end

    // Set beats a clear written in the same cycle, so no event is lost
    next_st.ext_pin_request_flag = next_flag(st.ext_pin_request_flag,
      evt.pin_event, wr_request_one,
      reg_wdata[EXT_PIN_BIT]);
    next_st.low_timer_match_request_flag = next_flag(
      st.low_timer_match_request_flag, low_match_event, wr_request_two,
      reg_wdata[LOW_TIMER_MATCH_BIT]);
    next_st.reload_timer_request_flag = next_flag(
      st.reload_timer_request_flag, reload_wrap, wr_request_two,
      reg_wdata[RELOAD_TIMER_BIT]);

    // Outputs follow the new flags so they line up with the register
    next_st.ext_int = next_st.ext_pin_request_flag &
                      next_st.ext_pin_int_enable;
    next_st.low_int = next_st.low_timer_match_request_flag &
                      next_st.low_timer_match_int_enable;
    next_st.reload_int = next_st.reload_timer_request_flag &
                         next_st.reload_timer_int_enable;
    next_st.irq = next_st.ext_int | next_st.low_int |
                  next_st.reload_int;

    // Read data stand for the one cycle after the strobe only
    next_st.rdata = '0;
    if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_INT_ENABLE_ONE: next_st.rdata = enable_one_view;
        ADDR_INT_ENABLE_TWO: next_st.rdata = enable_two_view;
        ADDR_INT_REQUEST_ONE: next_st.rdata = request_one_view;
        ADDR_INT_REQUEST_TWO: next_st.rdata = request_two_view;
        ADDR_LOW_HALF_COUNTER: next_st.rdata = evt.count;
        ADDR_LOW_HALF_COMPARE: next_st.rdata = st.compare;
        ADDR_EVENT_CONTROL: next_st.rdata = st.control;
        default: next_st.rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.ext_pin_int_enable <= INT_ENABLE_ONE_RST[EXT_PIN_BIT];
      st.low_timer_match_int_enable <=
        INT_ENABLE_TWO_RST[LOW_TIMER_MATCH_BIT];
      st.reload_timer_int_enable <= INT_ENABLE_TWO_RST[RELOAD_TIMER_BIT];
      st.control <= EVENT_CONTROL_RST;
      st.compare <= LOW_HALF_COMPARE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign ext_pin_int = st.ext_int;
  assign low_timer_match_int = st.low_int;
  assign reload_timer_int = st.reload_int;
  assign cpu_irq = st.irq;

endmodule : ifer_core

// ---- ifer_pkg.sv ----
// Shared constants for the interrupt flag and enable registers
package ifer_pkg;

  // ------------------------------------------------------------------
  // Bus widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] ADDR_INT_ENABLE_ONE = 16'hFFF3;
  localparam logic [15:0] ADDR_INT_ENABLE_TWO = 16'hFFF4;
  localparam logic [15:0] ADDR_INT_REQUEST_ONE = 16'hFFF6;
  localparam logic [15:0] ADDR_INT_REQUEST_TWO = 16'hFFF7;
  localparam logic [15:0] ADDR_LOW_HALF_COUNTER = 16'hFFB9;
  localparam logic [15:0] ADDR_LOW_HALF_COMPARE = 16'hFFBB;
  localparam logic [15:0] ADDR_EVENT_CONTROL = 16'hFFF8;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int EXT_PIN_BIT = 0;
  localparam int RELOAD_TIMER_BIT = 1;
  localparam int LOW_TIMER_MATCH_BIT = 2;
  localparam int CTRL_PIN_IRQ_MODE_BIT = 0;
  localparam int CTRL_PIN_RISING_BIT = 1;
  localparam int CTRL_MODE_8BIT_BIT = 2;
  localparam int CTRL_CLEAR_ON_MATCH_BIT = 3;

  // ------------------------------------------------------------------
  // Implemented bits and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_ONE_MASK = 8'h01;
  localparam logic [7:0] REG_TWO_MASK = 8'h06;
  localparam logic [7:0] CTRL_MASK = 8'h0F;
  localparam logic [7:0] INT_ENABLE_ONE_RST = 8'h00;
  localparam logic [7:0] INT_ENABLE_TWO_RST = 8'h00;
  localparam logic [7:0] EVENT_CONTROL_RST = 8'h00;
  localparam logic [7:0] LOW_HALF_COUNTER_RST = 8'h00;
  localparam logic [7:0] LOW_HALF_COMPARE_RST = 8'hFF;
  localparam logic [7:0] WRAP_HIGH = 8'hFF;
  localparam logic [7:0] WRAP_LOW = 8'h00;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int REF_CLK_PERIOD_NS = 4;
  localparam logic [1:0] TIMER_PRESCALE_LAST = 2'h3;

endpackage : ifer_pkg

// ---- ifer_evt_if.sv ----
// Event and timer signals between the core and its two helpers
`timescale 1ns/10ps
interface ifer_evt_if;
  logic pin_irq_mode;
  logic pin_rising;
  logic pin_event;
  logic mode_8bit;
  logic clear_on_match;
  logic count_load;
  logic [7:0] count_wdata;
  logic [7:0] compare;
  logic [7:0] count;
  logic match;

  modport core
  (
    output pin_irq_mode,
    output pin_rising,
    output mode_8bit,
    output clear_on_match,
    output count_load,
    output count_wdata,
    output compare,
    input pin_event,
    input count,
    input match
  );

  modport pin
  (
    input pin_irq_mode,
    input pin_rising,
    output pin_event
  );

  modport timer
  (
    input mode_8bit,
    input clear_on_match,
    input count_load,
    input count_wdata,
    input compare,
    output count,
    output match
  );
endinterface : ifer_evt_if

// ---- ifer_pin_edge.sv ----
// Synchroniser and edge detector for the external interrupt pin
`timescale 1ns/10ps
module ifer_pin_edge
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_interrupt_pin,
  ifer_evt_if.pin evt
);
  import ifer_pkg::*;

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic prev;
    logic event_pulse;
  } ifer_pin_t;

  ifer_pin_t st;
  ifer_pin_t next_st;
  logic rise;
  logic fall;

  // ------------------------------------------------------------------
  // Edge selection
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.sync_first = ext_interrupt_pin;
    next_st.sync_second = st.sync_first;
    next_st.prev = st.sync_second;
    rise = st.sync_second & ~st.prev;
    fall = ~st.sync_second & st.prev;
    // Only a pin set up as an interrupt input raises events
    next_st.event_pulse = evt.pin_irq_mode &
                          (evt.pin_rising ? rise : fall);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign evt.pin_event = st.event_pulse;

endmodule : ifer_pin_edge

// ---- ifer_low_timer.sv ----
// Low half 8-bit up-counter with compare match
`timescale 1ns/10ps
module ifer_low_timer
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  ifer_evt_if.timer evt
);
  import ifer_pkg::*;

  typedef struct packed {
    logic [1:0] prescale;
    logic [7:0] count;
    logic match;
  } ifer_timer_t;

  ifer_timer_t st;
  ifer_timer_t next_st;
  logic tick;

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.match = 1'b0;
    tick = (st.prescale == TIMER_PRESCALE_LAST);
    next_st.prescale = tick ? 2'h0 : st.prescale + 2'h1;
    if (evt.count_load)
    begin
      // Software write beats a count on the same cycle
      next_st.count = evt.count_wdata;
    end
    else if (tick)
    begin
      if (evt.mode_8bit && st.count == evt.compare)
      begin
        next_st.match = 1'b1;
        next_st.count = evt.clear_on_match ? LOW_HALF_COUNTER_RST
                                           : st.count + 8'h01;
      end
      else
      begin
        next_st.count = st.count + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign evt.count = st.count;
  assign evt.match = st.match;

endmodule : ifer_low_timer

// ---- ifer_core_monitor.sv ----
// Port checker for the interrupt flag and enable register block
`timescale 1ns/10ps
module ifer_core_monitor
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ifer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ifer_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [ifer_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ext_interrupt_pin,
  input wire logic [7:0] reload_count,
  input wire logic ext_pin_int,
  input wire logic low_timer_match_int,
  input wire logic reload_timer_int,
  input wire logic cpu_irq
);
  import ifer_pkg::*;
  logic [7:0] en1;
  logic [7:0] en2;
  logic [7:0] ctl;
  logic pin_d;
  logic [2:0] pin_q;
  logic [2:0] rc_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Shadow registers and quiet counters
  // ----------------------------------------------------------------
  // Quiet counters keep clear checks away from a pending set, which wins
  always_ff @(posedge ref_clk)
  begin
    pin_d <= ext_interrupt_pin;
    if (sys_rst)
    begin
      en1 <= 8'h00;
      en2 <= 8'h00;
      ctl <= 8'h00;
      pin_q <= 3'h0;
      rc_q <= 3'h0;
    end
    else
    begin
      if (reg_write && reg_addr == ADDR_INT_ENABLE_ONE)
        en1 <= reg_wdata;
      if (reg_write && reg_addr == ADDR_INT_ENABLE_TWO)
        en2 <= reg_wdata;
      if (reg_write && reg_addr == ADDR_EVENT_CONTROL)
        ctl <= reg_wdata;
      if (ext_interrupt_pin != pin_d)
        pin_q <= 3'h0;
      else if (pin_q != 3'h7)
        pin_q <= pin_q + 3'h1;
      if (reload_count == WRAP_HIGH || reload_count == WRAP_LOW)
        rc_q <= 3'h0;
      else if (rc_q != 3'h7)
        rc_q <= rc_q + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence pin_rise_armed;
    $rose(ext_interrupt_pin) && ctl[0] && ctl[1] && en1[0];
  endsequence
  sequence bus_quiet;
    (!reg_write)[*7];
  endsequence
  chk_pin_flag_set: assert property (pin_rise_armed ##0 bus_quiet |-> ext_pin_int)
    else $error("pin edge did not raise its interrupt");
  chk_pin_masked: assert property (!en1[0] |-> !ext_pin_int)
    else $error("pin interrupt while disabled");
  chk_low_masked: assert property (!en2[2] |-> !low_timer_match_int)
    else $error("low match interrupt while disabled");
  chk_reload_masked: assert property (!en2[1] |-> !reload_timer_int)
    else $error("reload interrupt while disabled");
  chk_pin_clear: assert property (reg_write && pin_q == 3'h7 &&
    reg_addr == ADDR_INT_REQUEST_ONE && !reg_wdata[0] |=> !ext_pin_int)
    else $error("pin flag not cleared by zero");
  chk_match_mode: assert property ($rose(low_timer_match_int) &&
    !$past(reg_write) |-> $past(ctl[2]) || $past(ctl[2], 2))
    else $error("low match flag set outside 8-bit mode");
  chk_low_clear: assert property (reg_write && !$past(ctl[2]) && !ctl[2] &&
    reg_addr == ADDR_INT_REQUEST_TWO && !reg_wdata[2] |=> !low_timer_match_int)
    else $error("low match flag not cleared by zero");
  chk_reload_set: assert property (!$past(sys_rst) && en2[1] && !reg_write &&
    ($past(reload_count) == WRAP_HIGH && reload_count == WRAP_LOW ||
    $past(reload_count) == WRAP_LOW && reload_count == WRAP_HIGH)
    |-> ##[1:2] reload_timer_int)
    else $error("reload wrap did not raise its interrupt");
  chk_reload_clear: assert property (reg_write && rc_q == 3'h7 &&
    reload_count != WRAP_LOW && reload_count != WRAP_HIGH &&
    reg_addr == ADDR_INT_REQUEST_TWO && !reg_wdata[1] |=> !reload_timer_int)
    else $error("reload flag not cleared by zero");
  chk_write_one_keeps: assert property (ext_pin_int && reg_write &&
    reg_addr == ADDR_INT_REQUEST_ONE && reg_wdata[0] |=> ext_pin_int)
    else $error("writing one disturbed the pin flag");
  chk_irq_is_or: assert property (cpu_irq ==
    (ext_pin_int || low_timer_match_int || reload_timer_int))
    else $error("cpu request is not the OR of the sources");
  chk_enable_read: assert property (reg_read &&
    reg_addr == ADDR_INT_ENABLE_TWO |=> reg_rdata == ($past(en2) & REG_TWO_MASK))
    else $error("enable two reads wrong");
endmodule : ifer_core_monitor

bind ifer_core ifer_core_monitor u_monitor
(
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .ext_interrupt_pin(ext_interrupt_pin),
  .reload_count(reload_count), .ext_pin_int(ext_pin_int),
  .low_timer_match_int(low_timer_match_int),
  .reload_timer_int(reload_timer_int), .cpu_irq(cpu_irq)
);

// ---- ifer_cpu_model.sv ----
// CPU core model that takes interrupts from the block
`timescale 1ns/10ps
module ifer_cpu_model
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cpu_irq,
  output int taken
);
  logic irq_d;
  // A level request counts once, when it first appears
  always_ff @(posedge ref_clk)
  begin
    irq_d <= cpu_irq;
    if (sys_rst)
      taken <= 0;
    else if (cpu_irq && !irq_d)
      taken <= taken + 1;
  end
endmodule : ifer_cpu_model

// ---- ifer_core_tb_top.sv ----
// Self-checking bench for the interrupt flag and enable register block
`timescale 1ns/10ps
module ifer_core_tb_top;
  import ifer_pkg::*;
  typedef struct packed {logic [15:0] addr; logic [7:0] wd; logic [7:0] rx;} ifer_row_t;
  logic ref_clk;
  logic sys_rst;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic ext_interrupt_pin;
  logic [7:0] reload_count;
  logic ext_pin_int;
  logic low_timer_match_int;
  logic reload_timer_int;
  logic cpu_irq;
  logic [7:0] v;
  int fail_count;
  int comparisons;
  int cycles;
  int taken;
  int n;
  ifer_row_t rows [10];
  ifer_core dut
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_interrupt_pin(ext_interrupt_pin),
    .reload_count(reload_count), .ext_pin_int(ext_pin_int),
    .low_timer_match_int(low_timer_match_int),
    .reload_timer_int(reload_timer_int), .cpu_irq(cpu_irq)
  );
  ifer_cpu_model cpu
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cpu_irq(cpu_irq), .taken(taken)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
    comparisons++;
    if (seen !== ex)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'h0;
    step(1);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'h0;
    step(1);
    d = reg_rdata;
  endtask : rd
  // Pin and reload value are held long enough for the synchroniser
  task automatic pin_to(input logic lvl);
    @(posedge ref_clk);
    ext_interrupt_pin <= lvl;
    step(8);
  endtask : pin_to
  task automatic load(input logic [7:0] c);
    @(posedge ref_clk);
    reload_count <= c;
    step(8);
  endtask : load
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'h1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_write = 1'h0;
    reg_read = 1'h0;
    ext_interrupt_pin = 1'h0;
    reload_count = 8'h10;
    rows = '{'{ADDR_EVENT_CONTROL, 8'hFF, 8'h0F}, '{ADDR_EVENT_CONTROL, 8'h00, 8'h00},
      '{ADDR_INT_ENABLE_ONE, 8'hFF, 8'h01}, '{ADDR_INT_ENABLE_ONE, 8'h00, 8'h00},
      '{ADDR_INT_ENABLE_TWO, 8'hFF, 8'h06}, '{ADDR_INT_ENABLE_TWO, 8'h00, 8'h00},
      '{ADDR_INT_REQUEST_ONE, 8'hFF, 8'h00}, '{ADDR_INT_REQUEST_TWO, 8'hFF, 8'h00},
      '{ADDR_LOW_HALF_COMPARE, 8'h5A, 8'h5A}, '{16'hFFF5, 8'hFF, 8'h00}};
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    step(1);
    chk("irq after reset", 8'(cpu_irq), 8'h00);
    rd(ADDR_LOW_HALF_COMPARE, v);
    chk("compare reset", v, LOW_HALF_COMPARE_RST);
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wd);
      rd(rows[i].addr, v);
      chk("register readback", v, rows[i].rx);
    end
    wr(ADDR_EVENT_CONTROL, 8'h03);
    wr(ADDR_INT_ENABLE_ONE, 8'h01);
    pin_to(1'h1);
    chk("pin rising", 8'(ext_pin_int), 8'h01);
    chk("cpu request", 8'(cpu_irq), 8'h01);
    wr(ADDR_INT_REQUEST_ONE, 8'h01);
    chk("write one", 8'(ext_pin_int), 8'h01);
    wr(ADDR_INT_ENABLE_ONE, 8'h00);
    chk("pin masked", 8'(ext_pin_int), 8'h00);
    rd(ADDR_INT_REQUEST_ONE, v);
    chk("pin flag held", v, 8'h01);
    wr(ADDR_INT_REQUEST_ONE, 8'h00);
    rd(ADDR_INT_REQUEST_ONE, v);
    chk("pin flag cleared", v, 8'h00);
    pin_to(1'h0);
    wr(ADDR_EVENT_CONTROL, 8'h01);
    wr(ADDR_INT_ENABLE_ONE, 8'h01);
    pin_to(1'h1);
    chk("wrong edge", 8'(ext_pin_int), 8'h00);
    pin_to(1'h0);
    chk("pin falling", 8'(ext_pin_int), 8'h01);
    wr(ADDR_INT_REQUEST_ONE, 8'h00);
    wr(ADDR_EVENT_CONTROL, 8'h00);
    pin_to(1'h1);
    pin_to(1'h0);
    rd(ADDR_INT_REQUEST_ONE, v);
    chk("pin not interrupt input", v, 8'h00);
    wr(ADDR_INT_ENABLE_TWO, 8'h02);
    load(8'h7F);
    load(8'h80);
    chk("no wrap", 8'(reload_timer_int), 8'h00);
    load(8'hFF);
    load(8'h00);
    chk("overflow", 8'(reload_timer_int), 8'h01);
    wr(ADDR_INT_REQUEST_TWO, 8'h00);
    chk("reload cleared", 8'(reload_timer_int), 8'h00);
    load(8'hFF);
    chk("underflow", 8'(reload_timer_int), 8'h01);
    load(8'h40);
    wr(ADDR_INT_ENABLE_TWO, 8'h00);
    chk("reload masked", 8'(reload_timer_int), 8'h00);
    wr(ADDR_INT_REQUEST_TWO, 8'h00);
    rd(ADDR_INT_REQUEST_TWO, v);
    chk("reload flag cleared", v, 8'h00);
    wr(ADDR_LOW_HALF_COMPARE, 8'h03);
    wr(ADDR_LOW_HALF_COUNTER, 8'h00);
    wr(ADDR_INT_ENABLE_TWO, 8'h04);
    step(40);
    chk("match outside mode", 8'(low_timer_match_int), 8'h00);
    wr(ADDR_EVENT_CONTROL, 8'h04);
    wr(ADDR_LOW_HALF_COUNTER, 8'h00);
    n = 0;
    while (low_timer_match_int !== 1'h1 && n < 40)
    begin
      step(1);
      n++;
    end
    chk("low match", 8'(low_timer_match_int), 8'h01);
    wr(ADDR_EVENT_CONTROL, 8'h00);
    step(4);
    wr(ADDR_INT_REQUEST_TWO, 8'h00);
    rd(ADDR_INT_REQUEST_TWO, v);
    chk("low flag cleared", v, 8'h00);
    wr(ADDR_LOW_HALF_COUNTER, 8'h20);
    rd(ADDR_LOW_HALF_COUNTER, v);
    chk("counter readback", 8'(v === 8'h20 || v === 8'h21), 8'h01);
    chk("cpu took requests", 8'(taken != 0), 8'h01);
    wrap_up();
  end
endmodule : ifer_core_tb_top
